// ==== design/prsr_pkg.sv ====
// package: register offsets, field positions, reset values and timing counts
// for the receive status and 10base-t operations register bank.
// assumes: used by prsr_regs, the checker and the testbench, never imported.
package prsr_pkg;
  // ----------------------------------------
  // register map (management register indices)
  // ----------------------------------------
  localparam logic [4:0] QSTAT_ADDR = 5'h11;
  localparam logic [4:0] TBOPS_ADDR = 5'h12;
  // ----------------------------------------
  // quick-status fields
  // ----------------------------------------
  localparam int QS_PLL_ERR = 9;
  localparam int QS_FALSE_CARRIER = 8;
  localparam int QS_INVALID_SYM = 7;
  localparam int QS_HALT_SYM = 6;
  localparam int QS_PREMATURE_END = 5;
  localparam int QS_AN_DONE = 4;
  localparam int QS_SIG_DETECT = 3;
  localparam int QS_JABBER = 2;
  localparam int QS_REMOTE_FAULT = 1;
  localparam int QS_LINK = 0;
  // ----------------------------------------
  // 10base-t operations fields
  // ----------------------------------------
  localparam int TB_REMOTE_JABBER = 15;
  localparam int TB_POL_REVERSED = 14;
  localparam int TB_JABBER_INH = 5;
  localparam int TB_RSVD_ONE = 4;
  localparam int TB_AUTOPOL_INH = 3;
  localparam int TB_SQE_INH = 2;
  localparam int TB_LINKLOSS_INH = 1;
  localparam int TB_SQUELCH_INH = 0;
  // control bits 5:0 reset value; bit 4 reserved reads one
  localparam logic [5:0] TB_CTRL_RESET = 6'h10;
  // ----------------------------------------
  // timing: 10 mb/s receive jabber window (ns) at a 4 ns clock
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int RX_JABBER_NS = 20000000;
  localparam int RX_JABBER_CYCLES = RX_JABBER_NS / CLK_PERIOD_NS;
  localparam int JAB_CNT_W = 24;
endpackage : prsr_pkg

// ==== design/prsr_latch_bit.sv ====
// latching status bit: captures an event until a read of its register.
// assumes: i_read_clr is a one-cycle pulse in the cycle the read is taken.
`timescale 1ns/1ps
module prsr_latch_bit #(
  parameter logic LATCH_LOW = 1'b0
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_event,
  input wire logic i_read_clr,
  output logic o_flag
);
  logic flag_r;
  logic flag_nxt;

  // a recurring event beats the read clear so nothing is lost
  always_comb begin
    if (i_event) begin
      flag_nxt = 1'b1;
    end else if (i_read_clr) begin
      flag_nxt = 1'b0;
    end else begin
      flag_nxt = flag_r;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // latch-low bits store the inverted sense
  assign o_flag = flag_r ^ LATCH_LOW;
endmodule : prsr_latch_bit

// ==== design/prsr_regs.sv ====
// register bank: quick-status and 10base-t operations registers of the phy.
// assumes: the management-frame engine presents a decoded register index
// with one-cycle read and write strobes; line-side events are clock-synchronous.
//
// What this block does
// - pll lock failure at 100 sets flag
// - error flags latch until read or reset
// - 100 start without valid j/k: false carrier
// - invalid symbol raises rx_er and flag
// - halt symbol signalled to mac, flag set
// - two idles inside packet: premature end
// - 100 mb/s flags meaningless at 10 mb/s
// - negotiation done bit zero when disabled
// - signal detect live, no latch
// - jabber bit mirrors basic status jabber
// - remote fault mirrors basic status bit
// - link bit mirrors latching-low link status
// - receive jabber latches, clears on read
// - remote jabber is report only
// - polarity reversal latched, receive continues
// - jabber inhibit disables transmit jabber check
// - auto polarity inhibit stops correction
// - sqe inhibit suppresses test pulses
// - link loss inhibit forces link pass
// - squelch inhibit needs data then idle
`timescale 1ns/1ps
module prsr_regs (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // management register access
  input wire logic [4:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  // line and pcs status
  input wire logic i_speed_100,
  input wire logic i_pll_lock_fail,
  input wire logic i_rx_activity_start,
  input wire logic i_rx_jk_valid,
  input wire logic i_rx_in_packet,
  input wire logic i_rx_sym_valid,
  input wire logic i_rx_sym_invalid,
  input wire logic i_rx_sym_halt,
  input wire logic i_rx_sym_idle,
  input wire logic i_an_enable,
  input wire logic i_an_complete,
  input wire logic i_sig_present,
  input wire logic i_bs_jabber,
  input wire logic i_bs_remote_fault,
  input wire logic i_bs_link,
  input wire logic i_rx10_active,
  input wire logic i_rx10_valid_data,
  input wire logic i_rx10_idle,
  input wire logic i_pol_reversed,
  // 100 mb/s receive indications and controls toward the 10base-t datapath
  output logic o_rx_er,
  output logic o_rx_halt,
  output logic o_jabber_check_en,
  output logic o_pol_correct_en,
  output logic o_sqe_test_en,
  output logic o_link_force_pass,
  output logic o_link10_ok
);
  // ----------------------------------------
  // access strobes
  // ----------------------------------------
  logic rd_qs;
  logic rd_tb;
  logic wr_tb;
  assign rd_qs = i_reg_rd && (i_reg_addr == prsr_pkg::QSTAT_ADDR);
  assign rd_tb = i_reg_rd && (i_reg_addr == prsr_pkg::TBOPS_ADDR);
  assign wr_tb = i_reg_wr && (i_reg_addr == prsr_pkg::TBOPS_ADDR);

  // ----------------------------------------
  // 100 mb/s receive event detection
  // ----------------------------------------
  logic prev_idle_r;
  logic prev_idle_nxt;
  logic rx_er_r;
  logic rx_er_nxt;
  logic rx_halt_r;
  logic rx_halt_nxt;
  logic [4:0] ev100;

  // events gated by 100 mode; at 10 the flags just stay quiet
  always_comb begin
    ev100[0] = i_speed_100 && i_rx_in_packet && i_rx_sym_valid && i_rx_sym_idle && prev_idle_r;
    ev100[1] = i_speed_100 && i_rx_in_packet && i_rx_sym_valid && i_rx_sym_halt;
    ev100[2] = i_speed_100 && i_rx_in_packet && i_rx_sym_valid && i_rx_sym_invalid;
    ev100[3] = i_speed_100 && i_rx_activity_start && !i_rx_jk_valid;
    ev100[4] = i_speed_100 && i_pll_lock_fail;
    prev_idle_nxt = i_rx_in_packet && i_rx_sym_valid ? i_rx_sym_idle : (i_rx_in_packet && prev_idle_r);
    rx_er_nxt = ev100[2];
    rx_halt_nxt = ev100[1];
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_idle_r <= 1'b0;
      rx_er_r <= 1'b0;
      rx_halt_r <= 1'b0;
    end else begin
      prev_idle_r <= prev_idle_nxt;
      rx_er_r <= rx_er_nxt;
      rx_halt_r <= rx_halt_nxt;
    end
  end

  // ----------------------------------------
  // latching flags: 5 error flags, jabber, fault, link, remote jabber, polarity
  // ----------------------------------------
  logic [9:0] lat_ev;
  logic [9:0] lat_clr;
  logic [9:0] lat_q;
  logic rx_jabber_ev;

  always_comb begin
    lat_ev[4:0] = ev100;
    lat_ev[5] = i_bs_jabber;
    lat_ev[6] = i_bs_remote_fault;
    lat_ev[7] = !i_bs_link;
    lat_ev[8] = rx_jabber_ev;
    lat_ev[9] = i_pol_reversed;
    lat_clr[7:0] = {8{rd_qs}};
    lat_clr[9:8] = {2{rd_tb}};
  end

  genvar gi;
  generate
    for (gi = 0; gi < 10; gi++) begin : g_lat
      prsr_latch_bit #(
        .LATCH_LOW(gi == 7)
      ) u_lat (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_event(lat_ev[gi]),
        .i_read_clr(lat_clr[gi]),
        .o_flag(lat_q[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // receive jabber timer (report only, no action)
  // ----------------------------------------
  logic [prsr_pkg::JAB_CNT_W-1:0] jab_cnt_r;
  logic [prsr_pkg::JAB_CNT_W-1:0] jab_cnt_nxt;
  localparam logic [prsr_pkg::JAB_CNT_W-1:0] JAB_LIMIT = prsr_pkg::JAB_CNT_W'(prsr_pkg::RX_JABBER_CYCLES - 1);

  always_comb begin
    if (!i_speed_100 && i_rx10_active) begin
      jab_cnt_nxt = (jab_cnt_r == JAB_LIMIT) ? jab_cnt_r : jab_cnt_r + 1'b1;
    end else begin
      jab_cnt_nxt = '0;
    end
    rx_jabber_ev = (jab_cnt_r == JAB_LIMIT);
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      jab_cnt_r <= '0;
    end else begin
      jab_cnt_r <= jab_cnt_nxt;
    end
  end

  // ----------------------------------------
  // 10base-t control bits
  // ----------------------------------------
  logic [5:0] ctrl_r;
  logic [5:0] ctrl_nxt;

  // reserved bit 4 held at one whatever is written; controller owes defaults
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_tb) begin
      ctrl_nxt = i_reg_wdata[5:0];
      ctrl_nxt[prsr_pkg::TB_RSVD_ONE] = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_r <= prsr_pkg::TB_CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ----------------------------------------
  // 10 mb/s link qualification
  // ----------------------------------------
  logic seen_data_r;
  logic seen_data_nxt;
  logic link10_nxt;
  logic link10_r;

  always_comb begin
    seen_data_nxt = seen_data_r || i_rx10_valid_data;
    if (ctrl_r[prsr_pkg::TB_LINKLOSS_INH]) begin
      link10_nxt = 1'b1;
    end else if (ctrl_r[prsr_pkg::TB_SQUELCH_INH]) begin
      link10_nxt = link10_r || (seen_data_r && i_rx10_idle);
    end else begin
      link10_nxt = link10_r || i_rx10_valid_data;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      seen_data_r <= 1'b0;
      link10_r <= 1'b0;
    end else begin
      seen_data_r <= seen_data_nxt;
      link10_r <= link10_nxt;
    end
  end

  // ----------------------------------------
  // status words
  // ----------------------------------------
  logic [15:0] qs_word;
  logic [15:0] tb_word;

  // upper quick-status bits live outside this bank and read zero
  always_comb begin
    qs_word = 16'h0000;
    qs_word[prsr_pkg::QS_PLL_ERR] = lat_q[4];
    qs_word[prsr_pkg::QS_FALSE_CARRIER] = lat_q[3];
    qs_word[prsr_pkg::QS_INVALID_SYM] = lat_q[2];
    qs_word[prsr_pkg::QS_HALT_SYM] = lat_q[1];
    qs_word[prsr_pkg::QS_PREMATURE_END] = lat_q[0];
    qs_word[prsr_pkg::QS_AN_DONE] = i_an_enable && i_an_complete;
    qs_word[prsr_pkg::QS_SIG_DETECT] = i_speed_100 && i_sig_present;
    qs_word[prsr_pkg::QS_JABBER] = lat_q[5];
    qs_word[prsr_pkg::QS_REMOTE_FAULT] = lat_q[6];
    qs_word[prsr_pkg::QS_LINK] = lat_q[7];
    tb_word = 16'h0000;
    tb_word[prsr_pkg::TB_REMOTE_JABBER] = lat_q[8];
    tb_word[prsr_pkg::TB_POL_REVERSED] = lat_q[9];
    tb_word[5:0] = ctrl_r;
  end

  // ----------------------------------------
  // read data and registered outputs
  // ----------------------------------------
  logic [15:0] rdata_nxt;
  logic [15:0] rdata_r;
  logic [5:0] out_nxt;
  logic [5:0] out_r;

  // a read returns the pre-clear flag values, the clear lands the same edge
  always_comb begin
    rdata_nxt = 16'h0000;
    if (i_reg_addr == prsr_pkg::QSTAT_ADDR) begin
      rdata_nxt = qs_word;
    end else if (i_reg_addr == prsr_pkg::TBOPS_ADDR) begin
      rdata_nxt = tb_word;
    end
  end

  // control outputs are registered so the datapath never sees a write glitch
  always_comb begin
    out_nxt[0] = !ctrl_r[prsr_pkg::TB_JABBER_INH];
    out_nxt[1] = !ctrl_r[prsr_pkg::TB_AUTOPOL_INH];
    out_nxt[2] = !ctrl_r[prsr_pkg::TB_SQE_INH];
    out_nxt[3] = ctrl_r[prsr_pkg::TB_LINKLOSS_INH];
    out_nxt[4] = link10_r;
    out_nxt[5] = 1'b0;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_r <= 16'h0000;
      out_r <= 6'h00;
    end else begin
      rdata_r <= rdata_nxt;
      out_r <= out_nxt;
    end
  end

  assign o_reg_rdata = rdata_r;
  assign o_rx_er = rx_er_r;
  assign o_rx_halt = rx_halt_r;
  assign o_jabber_check_en = out_r[0];
  assign o_pol_correct_en = out_r[1];
  assign o_sqe_test_en = out_r[2];
  assign o_link_force_pass = out_r[3];
  assign o_link10_ok = out_r[4];
endmodule : prsr_regs

// ==== sim/prsr_regs_props.sv ====
// checker: port-level timing of the receive status and 10base-t register bank
// assumes: bound into prsr_regs; one clock, reset async active high
`timescale 1ns/1ps
module prsr_regs_props (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [4:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  input wire logic i_speed_100,
  input wire logic i_pll_lock_fail,
  input wire logic i_rx_in_packet,
  input wire logic i_rx_sym_valid,
  input wire logic i_rx_sym_invalid,
  input wire logic i_rx_sym_halt,
  input wire logic i_an_enable,
  input wire logic i_an_complete,
  input wire logic i_sig_present,
  input wire logic o_rx_er,
  input wire logic o_rx_halt,
  input wire logic o_jabber_check_en,
  input wire logic o_pol_correct_en,
  input wire logic o_sqe_test_en,
  input wire logic o_link_force_pass
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wire logic sym_ok = i_speed_100 && i_rx_in_packet && i_rx_sym_valid;
  wire logic wr_ops = i_reg_wr && i_reg_addr == prsr_pkg::TBOPS_ADDR;
  wire logic at_qs = i_reg_addr == prsr_pkg::QSTAT_ADDR;
  a_rx_er_invalid: assert property (sym_ok && i_rx_sym_invalid |=> o_rx_er)
    else $error("rx error missing after invalid symbol");
  a_rx_er_cause: assert property (!(sym_ok && i_rx_sym_invalid) |=> !o_rx_er)
    else $error("rx error without invalid symbol");
  a_halt_to_mac: assert property (sym_ok && i_rx_sym_halt |=> o_rx_halt)
    else $error("halt not signalled");
  // control outputs settle within two edges of the write
  a_jabber_inh_ctrl: assert property (wr_ops ##1 1 |=> o_jabber_check_en == !$past(i_reg_wdata[5], 2))
    else $error("jabber check enable wrong");
  a_autopol_ctrl: assert property (wr_ops ##1 1 |=> o_pol_correct_en == !$past(i_reg_wdata[3], 2))
    else $error("polarity correction enable wrong");
  a_sqe_inh_ctrl: assert property (wr_ops ##1 1 |=> o_sqe_test_en == !$past(i_reg_wdata[2], 2))
    else $error("sqe test enable wrong");
  a_link_force_pass: assert property (wr_ops ##1 1 |=> o_link_force_pass == $past(i_reg_wdata[1], 2))
    else $error("link force pass wrong");
  a_pll_flag_set: assert property (i_speed_100 && i_pll_lock_fail ##1 at_qs |=> o_reg_rdata[9])
    else $error("pll lock error flag lost");
  a_sig_detect_live: assert property ((at_qs && i_speed_100 && i_sig_present) [*2] |=> o_reg_rdata[3])
    else $error("signal detect not shown");
  a_an_done_zero: assert property ((at_qs && !(i_an_enable && i_an_complete)) [*2] |=> !o_reg_rdata[4])
    else $error("negotiation done shown too early");
  c_ops_write: cover property (wr_ops);
  c_halt_seen: cover property (sym_ok && i_rx_sym_halt);
  c_read_with_event: cover property (i_reg_rd && at_qs && i_pll_lock_fail);
endmodule : prsr_regs_props

bind prsr_regs prsr_regs_props u_props (.*);

// ==== sim/prsr_sta_model.sv ====
// partner: station management side issuing register reads and writes
// assumes: bench calls rd and wr hierarchically; all changes at falling edge
`timescale 1ns/1ps
module prsr_sta_model (
  input wire logic i_ref_clk,
  input wire logic [15:0] i_reg_rdata,
  output logic [4:0] o_reg_addr,
  output logic o_reg_rd,
  output logic o_reg_wr,
  output logic [15:0] o_reg_wdata
);
  // ----------------------------------------
  // transfer tasks
  // ----------------------------------------
  initial begin
    o_reg_addr = 5'h00;
    o_reg_rd = 1'b0;
    o_reg_wr = 1'b0;
    o_reg_wdata = 16'h5a5a;
  end
  // address is left in place after a read, so data keeps following it
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge i_ref_clk);
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(negedge i_ref_clk);
    o_reg_rd = 1'b0;
    d = i_reg_rdata;
  endtask : rd
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge i_ref_clk);
    o_reg_addr = a;
    o_reg_wdata = (d & 16'hc02f) | 16'h0010;
    o_reg_wr = 1'b1;
    @(negedge i_ref_clk);
    o_reg_wr = 1'b0;
    // released data must not keep showing the written word
    o_reg_wdata = ~o_reg_wdata;
  endtask : wr
endmodule : prsr_sta_model

// ==== sim/testbench.sv ====
// testbench: status flags, control bits and 10base-t link logic of the bank
// assumes: design package and modules compiled first; 100 mb/s mode except one quick-status check at 10 mb/s
`timescale 1ns/1ps
module testbench;
  // ----------------------------------------
  // signals, model state and tasks
  // ----------------------------------------
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [4:0] i_reg_addr;
  logic i_reg_rd, i_reg_wr;
  logic [15:0] i_reg_wdata, o_reg_rdata, rd_v, rnd, ctrl;
  logic i_speed_100 = 1'b1, i_rx_jk_valid = 1'b0, i_an_enable = 1'b0, i_an_complete = 1'b0;
  logic i_sig_present = 1'b0, i_bs_link = 1'b1, i_rx10_active = 1'b0, i_rx10_valid_data = 1'b0;
  logic i_rx10_idle = 1'b0, i_pol_reversed = 1'b0, lnk = 1'b1;
  logic [6:0] ev = 7'h00;
  wire logic i_pll_lock_fail, i_rx_activity_start, i_rx_sym_invalid, i_rx_sym_halt, i_rx_sym_idle;
  wire logic i_bs_jabber, i_bs_remote_fault, i_rx_sym_valid, i_rx_in_packet;
  logic o_rx_er, o_rx_halt, o_jabber_check_en, o_pol_correct_en, o_sqe_test_en, o_link_force_pass, o_link10_ok;
  int fail_count = 0;
  int n_checks = 0;
  int qs_lat = 0;
  int ev_q[$] = {9, 8, 7, 6, 5, 2, 1};
  integer seed = 32'hb316f5b3;
  assign {i_pll_lock_fail, i_rx_activity_start, i_rx_sym_invalid, i_rx_sym_halt, i_rx_sym_idle} = ev[6:2];
  assign {i_bs_jabber, i_bs_remote_fault} = ev[1:0];
  assign i_rx_sym_valid = |ev[4:2];
  assign i_rx_in_packet = i_rx_sym_valid;
  prsr_regs dut (.*);
  prsr_sta_model sta (.i_ref_clk(i_ref_clk), .i_reg_rdata(o_reg_rdata), .o_reg_addr(i_reg_addr),
    .o_reg_rd(i_reg_rd), .o_reg_wr(i_reg_wr), .o_reg_wdata(i_reg_wdata));
  initial begin
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // idle events need two consecutive symbols, so that case is held a cycle longer
  task automatic hit(input int i);
    @(negedge i_ref_clk);
    ev = 7'h40 >> i;
    if (i == 4) @(negedge i_ref_clk);
    @(negedge i_ref_clk);
    ev = 7'h00;
  endtask : hit
  task automatic rdq(input string nm);
    sta.rd(prsr_pkg::QSTAT_ADDR, rd_v);
    chk(nm, 16'(qs_lat | (i_an_enable & i_an_complete) << 4 | (i_speed_100 & i_sig_present) << 3 | lnk), rd_v);
    qs_lat = 0;
    lnk = i_bs_link;
  endtask : rdq
  task automatic pulse10(input logic idle);
    @(negedge i_ref_clk);
    {i_rx10_valid_data, i_rx10_idle} = {!idle, idle};
    @(negedge i_ref_clk);
    {i_rx10_valid_data, i_rx10_idle} = 2'b00;
    repeat (2) @(negedge i_ref_clk);
  endtask : pulse10
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (10) @(negedge i_ref_clk);
    i_rst = 1'b0;
    sta.rd(prsr_pkg::TBOPS_ADDR, rd_v);
    chk("ops reset", 16'h0010, rd_v);
    chk("ctrl reset", 16'h000e, 16'({o_jabber_check_en, o_pol_correct_en, o_sqe_test_en, o_link_force_pass}));
    sta.rd(prsr_pkg::QSTAT_ADDR, rd_v);
    for (int i = 0; i < 7; i++) begin
      {i_an_enable, i_an_complete, i_sig_present} = 3'($random(seed));
      hit(i);
      qs_lat = 1 << ev_q[i];
      rdq("qs event");
      rdq("qs cleared");
    end
    fork
      sta.rd(prsr_pkg::QSTAT_ADDR, rd_v);
      hit(0);
    join
    qs_lat = 1 << 9;
    rdq("qs kept");
    @(negedge i_ref_clk);
    i_bs_link = 1'b0;
    @(negedge i_ref_clk);
    i_bs_link = 1'b1;
    lnk = 1'b0;
    rdq("link low");
    rdq("link back");
    i_pol_reversed = 1'b1;
    @(negedge i_ref_clk);
    i_pol_reversed = 1'b0;
    sta.rd(prsr_pkg::TBOPS_ADDR, rd_v);
    chk("pol set", 16'h4010, rd_v);
    sta.rd(prsr_pkg::TBOPS_ADDR, rd_v);
    chk("pol clr", 16'h0010, rd_v);
    sta.wr(prsr_pkg::TBOPS_ADDR, 16'h0011);
    pulse10(1'b0);
    chk("link10 data", 16'h0000, 16'(o_link10_ok));
    pulse10(1'b1);
    chk("link10 idle", 16'h0001, 16'(o_link10_ok));
    repeat (8) begin
      rnd = 16'($random(seed));
      sta.wr(prsr_pkg::TBOPS_ADDR, rnd);
      ctrl = (rnd & 16'h002f) | 16'h0010;
      sta.rd(prsr_pkg::TBOPS_ADDR, rd_v);
      chk("ops rw", ctrl, rd_v);
      chk("ctrl", 16'({~ctrl[5], ~ctrl[3], ~ctrl[2], ctrl[1]}),
        16'({o_jabber_check_en, o_pol_correct_en, o_sqe_test_en, o_link_force_pass}));
    end
    i_speed_100 = 1'b0;
    hit(0);
    rdq("qs at 10");
    i_speed_100 = 1'b1;
    sta.wr(prsr_pkg::QSTAT_ADDR, 16'hffff);
    sta.rd(5'h00, rd_v);
    chk("unmapped", 16'h0000, rd_v);
    rdq("qs after write");
    print_verdict();
  end
endmodule : testbench
